/* File: core/emtr_pkg.sv */
/*
 * constants, message codes and carrier structs of the express message engine.
 * assumes one clock domain (mclk, 50 MHz) and strobes that last one cycle.
 */
package emtr_pkg;

    // ------------------------------------------------------------
    // message codes and routings
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_ERR_COR = 8'h30;
    localparam logic [7:0] CODE_ERR_NONFATAL = 8'h31;
    localparam logic [7:0] CODE_ERR_FATAL = 8'h33;
    localparam logic [7:0] CODE_UNLOCK = 8'h00;
    localparam logic [7:0] CODE_SLOT_POWER = 8'h50;
    localparam logic [7:0] CODE_INTX_ASSERT = 8'h20;
    localparam logic [7:0] CODE_INTX_DEASSERT = 8'h24;
    localparam logic [4:0] CODE_INTX_GROUP = 5'h04;
    localparam logic [2:0] ROUTE_ROOT = 3'h0;
    localparam logic [2:0] ROUTE_BCAST = 3'h3;
    localparam logic [2:0] ROUTE_LOCAL = 3'h4;
    localparam logic [2:0] TC_ZERO = 3'h0;

    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int unsigned UNLOCK_SEND_BIT = 0;
    localparam int unsigned LEGACY_IRQ_ASSERT_BIT = 16;
    localparam int unsigned SLOT_VALUE_LSB = 7;
    localparam int unsigned SLOT_VALUE_MSB = 14;
    localparam int unsigned SLOT_SCALE_LSB = 15;
    localparam int unsigned SLOT_SCALE_MSB = 16;
    localparam logic [7:0] IRQ_LINE_NONE = 8'hff;
    localparam logic [7:0] IRQ_PIN_A = 8'h01;
    localparam logic [7:0] IRQ_PIN_D = 8'h04;

    // ------------------------------------------------------------
    // request sources, lowest index wins
    // ------------------------------------------------------------
    localparam int unsigned SRC_COR = 0;
    localparam int unsigned SRC_NONFATAL = 1;
    localparam int unsigned SRC_FATAL = 2;
    localparam int unsigned SRC_UNLOCK = 3;
    localparam int unsigned SRC_SLOT = 4;
    localparam int unsigned SRC_INTX = 5;
    localparam int unsigned SRC_SW = 6;
    localparam int unsigned NUM_SRC = 7;

    localparam int unsigned QUEUE_AW = 3;
    localparam logic [QUEUE_AW:0] QUEUE_DEPTH = 4'h8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] code;
        logic [2:0] routing;
        logic has_data;
        logic [2:0] tc;
        logic [63:0] addr;
        logic [31:0] data;
    } emtr_tlp_s;

    typedef struct packed {
        logic msg_issue_enable;
        logic msg_payload_select;
        logic [2:0] msg_routing_field;
        logic [7:0] msg_code_field;
    } emtr_msg_ctl_s;

    typedef struct packed {
        logic [7:0] irq_pin_select;
        logic [7:0] irq_line_field;
    } emtr_irq_cfg_s;

    typedef struct packed {
        logic [7:0] code;
        logic [2:0] tc;
    } emtr_rx_msg_s;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_HOLD = 1'b1
    } emtr_tx_state_e;

endpackage

/* File: core/emtr_req_queue.sv */
/*
 * small message queue: memory array with registered head word.
 * assumes the filler honours push_ready and the drainer pop_valid.
 */
`timescale 1ns/1ps
`default_nettype none

module emtr_req_queue import emtr_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic push_valid,
    output logic push_ready,
    input wire emtr_tlp_s push_data,
    output logic pop_valid,
    input wire logic pop_ready,
    output emtr_tlp_s pop_data
);

    // ------------------------------------------------------------
    // pointers and count
    // ------------------------------------------------------------
    emtr_tlp_s mem [0:(1 << QUEUE_AW) - 1];
    logic [QUEUE_AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [QUEUE_AW:0] cnt, next_cnt;
    logic head_valid, next_head_valid;
    logic push, load;

    always_comb begin
        push_ready = (cnt != QUEUE_DEPTH);
        push = push_valid & push_ready;
        load = (cnt != '0) & (~head_valid | pop_ready);
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = load ? rd_ptr + 1'b1 : rd_ptr;
        next_cnt = cnt + {{QUEUE_AW{1'b0}}, push} - {{QUEUE_AW{1'b0}}, load};
        if (load) begin
            next_head_valid = 1'b1;
        end else if (pop_ready) begin
            next_head_valid = 1'b0;
        end else begin
            next_head_valid = head_valid;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt <= '0;
            head_valid <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            cnt <= next_cnt;
            head_valid <= next_head_valid;
        end
    end

    // ------------------------------------------------------------
    // storage and registered read
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pop_data <= '0;
        end else if (load) begin
            pop_data <= mem[rd_ptr];
        end
    end

    assign pop_valid = head_valid;

endmodule

`default_nettype wire

/* File: core/emtr_rx_intx.sv */
/*
 * receive side: legacy interrupt status, interrupt lines, malformed check.
 * assumes rx_valid marks one decoded message per cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module emtr_rx_intx import emtr_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic root_port_mode,
    input wire logic rx_valid,
    input wire emtr_rx_msg_s rx_msg,
    input wire logic [7:0] irq_line_field,
    output logic [3:0] intx_status,
    output logic [3:0] intx_irq,
    output logic rx_malformed
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic is_intx(input logic [7:0] code);
        is_intx = (code[7:3] == CODE_INTX_GROUP);
    endfunction

    function automatic logic tc0_only(input logic [7:0] code);
        tc0_only = is_intx(code) | (code == CODE_ERR_COR) | (code == CODE_ERR_NONFATAL)
            | (code == CODE_ERR_FATAL) | (code == CODE_UNLOCK) | (code == CODE_SLOT_POWER);
    endfunction

    logic [3:0] next_status, next_irq;
    logic next_malformed;
    logic tc_bad;

    always_comb begin
        next_status = intx_status;
        tc_bad = (rx_msg.tc != TC_ZERO);
        if (rx_valid & is_intx(rx_msg.code) & ~tc_bad & root_port_mode) begin
            next_status[rx_msg.code[1:0]] = ~rx_msg.code[2];
        end
        next_malformed = rx_valid & tc0_only(rx_msg.code)
            & (tc_bad | (is_intx(rx_msg.code) & ~root_port_mode));
        next_irq = (irq_line_field != IRQ_LINE_NONE) ? next_status : 4'h0;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            intx_status <= 4'h0;
            intx_irq <= 4'h0;
            rx_malformed <= 1'b0;
        end else begin
            intx_status <= next_status;
            intx_irq <= next_irq;
            rx_malformed <= next_malformed;
        end
    end

endmodule

`default_nettype wire

/* File: core/emtr_msg_engine.sv */
/*
 * message engine top: automatic error messages, software triggered
 * messages, software built messages, queued transmit and INTx receive.
 * assumes register writes arrive as one-cycle strobes with data and that
 * the link side takes a message on tx_valid and tx_ready both high.
 */
// Function
// - correctable error sends ERR_COR when enabled
// - non-fatal error sends ERR_NONFATAL when enabled
// - fatal error sends ERR_FATAL when enabled
// - unlock bit write sends Unlock message
// - unlock only as Root Port
// - slot capability write sends power limit MsgD, only as Root Port
// - assert bit write sends Assert/Deassert for pin
// - INTx messages sent only as Endpoint
// - built message uses address, control; needs enable
// - data write launches one message; writes while one is still pending replace its contents
// - type bit picks Msg or MsgD payload
// - MsgD payload is exactly one doubleword
// - INTx codes per line, routing local
// - received Assert sets status, raises interrupt
// - received Deassert clears status, cancels interrupt
// - Endpoint treats received INTx as malformed
// - Deassert line D clears status bit three
// - nonzero traffic class on these is malformed
`timescale 1ns/1ps
`default_nettype none

module emtr_msg_engine import emtr_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic root_port_mode,
    input wire logic err_cor_en,
    input wire logic err_nonfatal_en,
    input wire logic err_fatal_en,
    input wire logic err_cor_det,
    input wire logic err_nonfatal_det,
    input wire logic err_fatal_det,
    input wire logic unlock_control_wr,
    input wire logic [31:0] unlock_control_wdata,
    input wire logic slot_capability_wr,
    input wire logic [31:0] slot_capability_wdata,
    input wire logic legacy_irq_wr,
    input wire logic [31:0] legacy_irq_wdata,
    input wire emtr_irq_cfg_s irq_config_word,
    input wire logic [31:0] msg_addr_low_reg,
    input wire logic [31:0] msg_addr_high_reg,
    input wire emtr_msg_ctl_s msg_control_reg,
    input wire logic msg_data_wr,
    input wire logic [31:0] msg_data_wdata,
    output logic tx_valid,
    input wire logic tx_ready,
    output emtr_tlp_s tx_msg,
    input wire logic rx_valid,
    input wire emtr_rx_msg_s rx_msg,
    output logic [NUM_SRC-1:0] msg_pending,
    output logic legacy_irq_assert_bit,
    output logic [3:0] intx_status,
    output logic [3:0] intx_irq,
    output logic rx_malformed
);

    // ------------------------------------------------------------
    // message builder
    // ------------------------------------------------------------
    function automatic emtr_tlp_s make_tlp(
        input logic [7:0] code,
        input logic [2:0] routing,
        input logic has_data,
        input logic [63:0] addr,
        input logic [31:0] data
    );
        emtr_tlp_s t;
        t.code = code;
        t.routing = routing;
        t.has_data = has_data;
        t.tc = TC_ZERO;
        t.addr = addr;
        t.data = has_data ? data : 32'h0;
        make_tlp = t;
    endfunction

    // ------------------------------------------------------------
    // receive side
    // ------------------------------------------------------------
    emtr_rx_intx u_rx (
        .mclk(mclk),
        .rst(rst),
        .root_port_mode(root_port_mode),
        .rx_valid(rx_valid),
        .rx_msg(rx_msg),
        .irq_line_field(irq_config_word.irq_line_field),
        .intx_status(intx_status),
        .intx_irq(intx_irq),
        .rx_malformed(rx_malformed)
    );

    // ------------------------------------------------------------
    // request capture
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] req;
    logic pin_ok;
    logic [1:0] pin_idx;
    logic [7:0] pin_sel;

    always_comb begin
        pin_sel = irq_config_word.irq_pin_select;
        pin_ok = (pin_sel >= IRQ_PIN_A) & (pin_sel <= IRQ_PIN_D);
        pin_idx = 2'(pin_sel - IRQ_PIN_A);
        req = '0;
        req[SRC_COR] = err_cor_det & err_cor_en;
        req[SRC_NONFATAL] = err_nonfatal_det & err_nonfatal_en;
        req[SRC_FATAL] = (err_fatal_det | rx_malformed) & err_fatal_en;
        req[SRC_UNLOCK] = unlock_control_wr & unlock_control_wdata[UNLOCK_SEND_BIT]
            & root_port_mode;
        req[SRC_SLOT] = slot_capability_wr & root_port_mode;
        req[SRC_INTX] = legacy_irq_wr & ~root_port_mode & pin_ok;
        req[SRC_SW] = msg_data_wr & msg_control_reg.msg_issue_enable;
    end

    // ------------------------------------------------------------
    // payload holding registers
    // ------------------------------------------------------------
    emtr_tlp_s slot_msg, next_slot_msg;
    emtr_tlp_s intx_msg, next_intx_msg;
    emtr_tlp_s sw_msg, next_sw_msg;
    logic next_assert_bit;
    logic [7:0] intx_code;

    always_comb begin
        next_slot_msg = slot_msg;
        next_intx_msg = intx_msg;
        next_sw_msg = sw_msg;
        next_assert_bit = legacy_irq_assert_bit;
        intx_code = legacy_irq_wdata[LEGACY_IRQ_ASSERT_BIT]
            ? (CODE_INTX_ASSERT | {6'h0, pin_idx})
            : (CODE_INTX_DEASSERT | {6'h0, pin_idx});
        if (req[SRC_SLOT]) begin
            next_slot_msg = make_tlp(CODE_SLOT_POWER, ROUTE_LOCAL, 1'b1, 64'h0,
                {22'h0, slot_capability_wdata[SLOT_SCALE_MSB:SLOT_SCALE_LSB],
                slot_capability_wdata[SLOT_VALUE_MSB:SLOT_VALUE_LSB]});
        end
        if (req[SRC_INTX]) begin
            next_intx_msg = make_tlp(intx_code, ROUTE_LOCAL, 1'b0, 64'h0, 32'h0);
        end
        if (legacy_irq_wr & ~root_port_mode) begin
            next_assert_bit = legacy_irq_wdata[LEGACY_IRQ_ASSERT_BIT];
        end
        if (req[SRC_SW]) begin
            next_sw_msg = make_tlp(msg_control_reg.msg_code_field,
                msg_control_reg.msg_routing_field,
                msg_control_reg.msg_payload_select,
                {msg_addr_high_reg, msg_addr_low_reg},
                msg_data_wdata);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            slot_msg <= '0;
            intx_msg <= '0;
            sw_msg <= '0;
            legacy_irq_assert_bit <= 1'b0;
        end else begin
            slot_msg <= next_slot_msg;
            intx_msg <= next_intx_msg;
            sw_msg <= next_sw_msg;
            legacy_irq_assert_bit <= next_assert_bit;
        end
    end

    // ------------------------------------------------------------
    // pending flags and arbiter
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] next_pending, grant;
    logic push_ready, push_valid, found;
    emtr_tlp_s push_data;

    always_comb begin
        grant = '0;
        found = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (msg_pending[i] & ~found & push_ready) begin
                grant[i] = 1'b1;
                found = 1'b1;
            end
        end
        push_valid = found;
        // set wins over the grant clear
        next_pending = (msg_pending & ~grant) | req;
    end

    always_comb begin
        if (grant[SRC_COR]) begin
            push_data = make_tlp(CODE_ERR_COR, ROUTE_ROOT, 1'b0, 64'h0, 32'h0);
        end else if (grant[SRC_NONFATAL]) begin
            push_data = make_tlp(CODE_ERR_NONFATAL, ROUTE_ROOT, 1'b0, 64'h0, 32'h0);
        end else if (grant[SRC_FATAL]) begin
            push_data = make_tlp(CODE_ERR_FATAL, ROUTE_ROOT, 1'b0, 64'h0, 32'h0);
        end else if (grant[SRC_UNLOCK]) begin
            push_data = make_tlp(CODE_UNLOCK, ROUTE_BCAST, 1'b0, 64'h0, 32'h0);
        end else if (grant[SRC_SLOT]) begin
            push_data = slot_msg;
        end else if (grant[SRC_INTX]) begin
            push_data = intx_msg;
        end else begin
            push_data = sw_msg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            msg_pending <= '0;
        end else begin
            msg_pending <= next_pending;
        end
    end

    // ------------------------------------------------------------
    // ordered queue
    // ------------------------------------------------------------
    logic q_valid, q_pop;
    emtr_tlp_s q_data;

    emtr_req_queue u_queue (
        .mclk(mclk),
        .rst(rst),
        .push_valid(push_valid),
        .push_ready(push_ready),
        .push_data(push_data),
        .pop_valid(q_valid),
        .pop_ready(q_pop),
        .pop_data(q_data)
    );

    // ------------------------------------------------------------
    // transmit stage
    // ------------------------------------------------------------
    emtr_tx_state_e tx_state, next_tx_state;
    emtr_tlp_s next_tx_msg;
    logic next_tx_valid;

    always_comb begin
        q_pop = q_valid & ((tx_state == TX_IDLE) | tx_ready);
        next_tx_state = tx_state;
        next_tx_msg = tx_msg;
        case (tx_state)
            TX_IDLE: begin
                if (q_pop) begin
                    next_tx_state = TX_HOLD;
                    next_tx_msg = q_data;
                end
            end
            TX_HOLD: begin
                if (tx_ready) begin
                    if (q_pop) begin
                        next_tx_msg = q_data;
                    end else begin
                        next_tx_state = TX_IDLE;
                    end
                end
            end
            default: begin
                next_tx_state = TX_IDLE;
            end
        endcase
        next_tx_valid = (next_tx_state == TX_HOLD);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_state <= TX_IDLE;
            tx_msg <= '0;
            tx_valid <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_msg <= next_tx_msg;
            tx_valid <= next_tx_valid;
        end
    end

endmodule

`default_nettype wire

/* File: testbench/emtr_msg_engine_sva.sv */
/*
 * port checker of the express message engine, bound to its top module.
 * assumes one clock domain, mclk, with rst asynchronous and active high.
 */
`timescale 1ns/1ps
`default_nettype none

module emtr_msg_engine_sva import emtr_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic root_port_mode,
    input wire logic err_cor_en,
    input wire logic err_nonfatal_en,
    input wire logic err_fatal_en,
    input wire logic err_cor_det,
    input wire logic err_nonfatal_det,
    input wire logic err_fatal_det,
    input wire logic unlock_control_wr,
    input wire logic [31:0] unlock_control_wdata,
    input wire logic slot_capability_wr,
    input wire logic legacy_irq_wr,
    input wire emtr_irq_cfg_s irq_config_word,
    input wire emtr_msg_ctl_s msg_control_reg,
    input wire logic msg_data_wr,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire emtr_tlp_s tx_msg,
    input wire logic rx_valid,
    input wire emtr_rx_msg_s rx_msg,
    input wire logic [NUM_SRC-1:0] msg_pending,
    input wire logic [3:0] intx_status,
    input wire logic [3:0] intx_irq,
    input wire logic rx_malformed
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_cor_gate: assert property (err_cor_det && !msg_pending[SRC_COR] |=>
        msg_pending[SRC_COR] == $past(err_cor_en)) else $error("cor request gating wrong");
    a_nonfatal_gate: assert property (err_nonfatal_det && !msg_pending[SRC_NONFATAL] |=>
        msg_pending[SRC_NONFATAL] == $past(err_nonfatal_en)) else $error("nonfatal request gating wrong");
    a_fatal_gate: assert property (err_fatal_det && err_fatal_en |=> msg_pending[SRC_FATAL])
        else $error("fatal request lost");
    a_unlock_gate: assert property (unlock_control_wr && !msg_pending[SRC_UNLOCK] |=>
        msg_pending[SRC_UNLOCK] == ($past(unlock_control_wdata[0]) && $past(root_port_mode)))
        else $error("unlock request gating wrong");
    a_slot_gate: assert property (slot_capability_wr && !msg_pending[SRC_SLOT] |=>
        msg_pending[SRC_SLOT] == $past(root_port_mode)) else $error("slot request gating wrong");
    a_intx_root: assert property (legacy_irq_wr && root_port_mode && !msg_pending[SRC_INTX] |=>
        !msg_pending[SRC_INTX]) else $error("intx request taken as root");
    a_sw_gate: assert property (msg_data_wr && !msg_pending[SRC_SW] |=>
        msg_pending[SRC_SW] == $past(msg_control_reg.msg_issue_enable)) else $error("sw request gating wrong");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_msg))
        else $error("message changed before taken");
    a_intx_route: assert property (tx_valid && tx_msg.code[7:3] == 5'h04 |->
        tx_msg.routing == ROUTE_LOCAL && !tx_msg.has_data) else $error("intx routing wrong");
    a_rx_assert: assert property (rx_valid && root_port_mode && rx_msg.tc == TC_ZERO &&
        rx_msg.code[7:2] == 6'h08 |=> intx_status[$past(rx_msg.code[1:0])]) else $error("status not set");
    a_rx_deassert: assert property (rx_valid && root_port_mode && rx_msg.tc == TC_ZERO &&
        rx_msg.code[7:2] == 6'h09 |=> !intx_status[$past(rx_msg.code[1:0])]) else $error("status not cleared");
    a_irq_mask: assert property (intx_irq ==
        (intx_status & {4{$past(irq_config_word.irq_line_field) != IRQ_LINE_NONE}})) else $error("irq mask wrong");
    a_rx_endpoint: assert property (rx_valid && !root_port_mode && rx_msg.code[7:3] == 5'h04
        |=> rx_malformed) else $error("endpoint intx not malformed");
    a_rx_tc: assert property (rx_valid && rx_msg.tc != TC_ZERO && rx_msg.code[7:3] == 5'h04
        |=> rx_malformed && $stable(intx_status)) else $error("nonzero class accepted");
endmodule

bind emtr_msg_engine emtr_msg_engine_sva u_sva (.mclk, .rst, .root_port_mode, .err_cor_en, .err_nonfatal_en,
    .err_fatal_en, .err_cor_det, .err_nonfatal_det, .err_fatal_det, .unlock_control_wr, .unlock_control_wdata,
    .slot_capability_wr, .legacy_irq_wr, .irq_config_word, .msg_control_reg, .msg_data_wr, .tx_valid,
    .tx_ready, .tx_msg, .rx_valid, .rx_msg, .msg_pending, .intx_status, .intx_irq, .rx_malformed);

`default_nettype wire

/* File: testbench/emtr_link_model.sv */
/*
 * link partner model: takes messages on the transmit handshake.
 * assumes the engine holds tx_valid and tx_msg until taken.
 */
`timescale 1ns/1ps
`default_nettype none

module emtr_link_model import emtr_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic slow,
    input wire logic tx_valid,
    input wire emtr_tlp_s tx_msg,
    output logic tx_ready,
    output logic taken,
    output emtr_tlp_s taken_msg
);
    logic [1:0] stall;

    // slow mode accepts one cycle in four
    assign tx_ready = !slow || stall == 2'h3;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stall <= 2'h0;
            taken <= 1'b0;
            taken_msg <= '0;
        end else begin
            stall <= stall + 2'h1;
            taken <= tx_valid && tx_ready;
            taken_msg <= tx_msg;
        end
    end
endmodule

`default_nettype wire

/* File: testbench/emtr_msg_engine_tb.sv */
/*
 * self-checking bench of the express message engine with a link partner.
 * assumes the checker is bound through its own file.
 */
`timescale 1ns/1ps
`default_nettype none

module emtr_msg_engine_tb import emtr_pkg::*;;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic root = 1'b1;
    logic slow = 1'b0;
    logic [2:0] en = 3'h0;
    logic [6:0] stb = 7'h0;
    logic [31:0] wd = 32'h0, alo = 32'h0, ahi = 32'h0;
    emtr_irq_cfg_s cfg = '0;
    emtr_msg_ctl_s ctl = '0;
    logic rx_valid = 1'b0;
    emtr_rx_msg_s rx_msg = '0;
    logic tx_valid, tx_ready, taken, legacy_irq_assert_bit, rx_malformed;
    emtr_tlp_s tx_msg, taken_msg;
    logic [NUM_SRC-1:0] msg_pending;
    logic [3:0] intx_status, intx_irq;
    int n_errors = 0;
    int comparisons = 0;
    emtr_tlp_s expq[$];
    logic [44:0] sw_tab [4] = '{{1'b1, 12'h319, 32'hdead_beef}, {1'b1, 12'hc50, 32'h1234_5678},
        {1'b0, 12'h018, 32'hffff_0000}, {1'b0, 12'h51b, 32'h0}};

    emtr_msg_engine DUT (.mclk, .rst, .root_port_mode(root), .err_cor_en(en[0]), .err_nonfatal_en(en[1]),
        .err_fatal_en(en[2]), .err_cor_det(stb[0]), .err_nonfatal_det(stb[1]), .err_fatal_det(stb[2]),
        .unlock_control_wr(stb[3]), .unlock_control_wdata(wd), .slot_capability_wr(stb[4]),
        .slot_capability_wdata(wd), .legacy_irq_wr(stb[5]), .legacy_irq_wdata(wd), .irq_config_word(cfg),
        .msg_addr_low_reg(alo), .msg_addr_high_reg(ahi), .msg_control_reg(ctl), .msg_data_wr(stb[6]),
        .msg_data_wdata(wd), .tx_valid, .tx_ready, .tx_msg, .rx_valid, .rx_msg, .msg_pending,
        .legacy_irq_assert_bit, .intx_status, .intx_irq, .rx_malformed);
    emtr_link_model LNK (.mclk, .rst, .slow, .tx_valid, .tx_msg, .tx_ready, .taken, .taken_msg);

    always #10 mclk = ~mclk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [110:0] seen, input logic [110:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic expect_tx(input logic [7:0] c, input logic [2:0] r, input logic d, input logic [31:0] v);
        expq.push_back({c, r, d, TC_ZERO, ahi, alo, d ? v : 32'h0});
    endtask

    task automatic drain();
        repeat (10) @(posedge mclk);
        for (int i = 0; i < 200 && expq.size() != 0; i++) @(posedge mclk);
        check(expq.size() == 0, 1'b1);
    endtask

    task automatic pulse(input logic [6:0] m);
        @(posedge mclk) stb <= m;
        @(posedge mclk) stb <= 7'h0;
        drain();
    endtask

    // exp holds malformed flag over the four status bits
    task automatic rx(input logic [7:0] c, input logic [2:0] t, input logic [4:0] exp);
        @(posedge mclk);
        if (exp[4] && en[2]) expect_tx(CODE_ERR_FATAL, ROUTE_ROOT, 1'b0, 32'h0);
        rx_valid <= 1'b1;
        rx_msg <= {c, t};
        @(posedge mclk);
        rx_valid <= 1'b0;
        #1;
        check({rx_malformed, intx_status}, exp);
        check(intx_irq, cfg.irq_line_field == IRQ_LINE_NONE ? 4'h0 : exp[3:0]);
        drain();
    endtask

    // link side: each taken message must be the oldest expected one
    always @(posedge mclk) begin
        if (taken) begin
            if (expq.size() == 0) check(1'b1, 1'b0);
            else check(taken_msg, expq.pop_front());
        end
    end

    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        #1;
        check({tx_valid, msg_pending, intx_status, intx_irq, rx_malformed, legacy_irq_assert_bit}, '0);
        pulse(7'h07);
        en <= 3'h7;
        slow <= 1'b1;
        expect_tx(CODE_ERR_COR, ROUTE_ROOT, 1'b0, 32'h0);
        expect_tx(CODE_ERR_NONFATAL, ROUTE_ROOT, 1'b0, 32'h0);
        expect_tx(CODE_ERR_FATAL, ROUTE_ROOT, 1'b0, 32'h0);
        pulse(7'h07);
        wd <= 32'h0001_4a80;
        expect_tx(CODE_SLOT_POWER, ROUTE_LOCAL, 1'b1, 32'h0000_0295);
        pulse(7'h18);
        wd <= 32'h0001_4a81;
        expect_tx(CODE_UNLOCK, ROUTE_BCAST, 1'b0, 32'h0);
        expect_tx(CODE_SLOT_POWER, ROUTE_LOCAL, 1'b1, 32'h0000_0295);
        pulse(7'h38);
        root <= 1'b0;
        pulse(7'h18);
        for (int p = 1; p <= 4; p++) begin
            for (int a = 1; a >= 0; a--) begin
                cfg <= {p[7:0], 8'h0a};
                wd <= {15'h0, a[0], 16'h0};
                expect_tx(8'((a ? CODE_INTX_ASSERT : CODE_INTX_DEASSERT) + p - 1), ROUTE_LOCAL, 1'b0, 32'h0);
                pulse(7'h20);
                check(legacy_irq_assert_bit, a[0]);
            end
        end
        alo <= 32'h8000_0010;
        ahi <= 32'h0000_0001;
        ctl <= {1'b0, 12'hc50};
        pulse(7'h40);
        for (int i = 0; i < 4; i++) begin
            root <= sw_tab[i][44];
            ctl <= {1'b1, sw_tab[i][43:32]};
            wd <= sw_tab[i][31:0];
            expect_tx(sw_tab[i][39:32], sw_tab[i][42:40], sw_tab[i][43], sw_tab[i][31:0]);
            pulse(7'h40);
        end
        alo <= 32'h0;
        ahi <= 32'h0;
        root <= 1'b1;
        cfg <= {8'h01, 8'h0a};
        for (int i = 0; i < 4; i++) rx(8'(CODE_INTX_ASSERT + i), TC_ZERO, {1'b0, 4'((2 << i) - 1)});
        rx(8'(CODE_INTX_DEASSERT + 3), TC_ZERO, 5'h07);
        rx(CODE_INTX_DEASSERT, 3'h1, 5'h17);
        cfg <= {8'h01, IRQ_LINE_NONE};
        rx(8'(CODE_INTX_ASSERT + 3), TC_ZERO, 5'h0f);
        root <= 1'b0;
        rx(CODE_INTX_ASSERT, TC_ZERO, 5'h1f);
        end_of_test();
    end
endmodule

`default_nettype wire
